// [hw/bgic_pkg.sv]
// Package for the graphics bus interface configuration register bank.
// Assumes one clock domain; host pins arrive asynchronous to it.
package bgic_pkg;
  // Block geometry
  localparam int ADDR_W = 16;
  localparam logic [7:0] BLOCK_BYTES = 8'h80;
  localparam logic [6:0] BIU_END = 7'h10;
  localparam int GMEM_DATA_W = 16;
  // Register word offsets within the block
  localparam logic [6:0] OFS_RELOC = 7'h00;
  localparam logic [6:0] OFS_IFCTL = 7'h04;
  localparam logic [6:0] OFS_REFR = 7'h06;
  localparam logic [6:0] OFS_GEOM = 7'h08;
  localparam logic [6:0] OFS_PDISP = 7'h0a;
  localparam logic [6:0] OFS_PDRAW = 7'h0c;
  localparam logic [6:0] OFS_PHOST = 7'h0e;
  localparam logic [6:0] OFS_OPCODE = 7'h20;
  localparam logic [6:0] OFS_LINKLO = 7'h22;
  localparam logic [6:0] OFS_LINKHI = 7'h24;
  // Field positions
  localparam int MIO_BIT = 0;
  localparam int VR_BIT = 6;
  localparam int WT_BIT = 5;
  localparam int HW_BIT = 4;
  localparam int GI_BIT = 3;
  localparam int DI_BIT = 2;
  localparam int WL1_BIT = 1;
  localparam int WL2_BIT = 0;
  localparam int ROW_LSB = 5;
  localparam int CFG_LSB = 3;
  localparam int HT_LSB = 0;
  localparam int FPL_LSB = 3;
  // Reset values
  localparam logic [15:0] RST_RELOC = 16'h0000;
  localparam logic [5:0] RST_REFR = 6'h12;
  localparam logic [6:0] RST_GEOM = 7'h65;
  localparam logic [5:0] RST_PDISP = 6'h3f;
  localparam logic [5:0] RST_PDRAW = 6'h2a;
  localparam logic [5:0] RST_PHOST = 6'h3f;
  // Refresh period is (scalar + 1) * REFR_UNIT clocks
  localparam int REFR_UNIT = 16;
  // Wait states before ready; the long pair applies with wait timing set in sync mode
  localparam logic [3:0] WAIT_WR_LONG = 4'h2;
  localparam logic [3:0] WAIT_RD_LONG = 4'h3;
  localparam logic [3:0] WAIT_WR_SHORT = 4'h1;
  localparam logic [3:0] WAIT_RD_SHORT = 4'h2;
  localparam logic [1:0] RST_SETTLE = 2'h2;

  // Host pins, as seen at the device boundary
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic mem_space;
    logic byte_high_enable_pin;
    logic [ADDR_W-1:0] addr;
    logic [15:0] data;
  } bgic_pins_type;

  // One requester priority pair
  typedef struct packed {
    logic [2:0] first_request_level;
    logic [2:0] subsequent_request_level;
  } bgic_prio_type;

  // Configuration seen by the rest of the device
  typedef struct packed {
    logic memory_space_select;
    logic video_memory_select;
    logic wait_timing_select;
    logic host_width_select;
    logic drawing_engine_irq_flag;
    logic display_engine_irq_flag;
    logic soft_write_lock;
    logic hard_write_lock;
    logic [5:0] refresh_scalar;
    logic [1:0] row_count;
    logic [1:0] memory_config_code;
    logic [2:0] chip_height_code;
    bgic_prio_type prio_disp;
    bgic_prio_type prio_draw;
    bgic_prio_type prio_host;
    logic sync_mode;
    logic memory_bus_wide;
  } bgic_cfg_type;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_HOLD} bgic_bus_type;
endpackage

// [hw/bgic_regs.sv]
// Configuration and control register bank of the graphics bus interface.
// Assumes host strobes and pins are asynchronous; engine events are local.
`timescale 1ns/1ps

// Notes on behaviour
// R1 - Decode 128-byte block at relocatable base
// R2 - Mapping bit picks memory or I/O space
// R3 - Unrelocated: relocation register at every 128-byte I/O
// R4 - Host must relocate before other accesses
// R5 - First I/O write hits registers, upper bits ignored
// R6 - Video select picks VRAM or page cycles
// R7 - Wait timing set in sync mode: 2 write, 3 read waits
// R8 - Byte host interface until width bit set
// R9 - Drawing irq flag set by event, cleared on read
// R10 - Display irq flag set by event, cleared on read
// R11 - Soft lock blocks interface set but lock bits
// R12 - Hard lock blocks interface set until reset
// R13 - Refresh every (scalar+1)*16 clocks
// R14 - Row code picks 1-4 rows, gates row strobes
// R15 - Config code picks page or fast page, interleave
// R16 - Height code 8K..1M, identical chips
// R17 - Priority pairs, 111 highest, 000 lowest
// R18 - Byte-high pin at reset end picks sync mode
// R19 - Sync choice alters strobe sampling and wait timing here
// R20 - Reset loads defaults, clears irq flags
// R21 - Graphics memory data always 16 bits
// R22 - Reserved writes complete, change nothing
// R23 - 10-bit refresh row, all rows together
// R24 - Locked writes still complete handshake
module bgic_regs
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Host pins
  input wire bgic_pkg::bgic_pins_type pins,
  output logic [15:0] data_out,
  output logic data_oe,
  output logic ready,
  // Engine events and memory requests
  input wire logic draw_irq_event,
  input wire logic disp_irq_event,
  input wire logic [2:0] mem_req,
  input wire logic [2:0] mem_req_burst,
  // Configuration and memory control
  output bgic_pkg::bgic_cfg_type cfg,
  output logic refresh_req,
  output logic [9:0] refresh_row,
  output logic [3:0] row_strobe_en,
  output logic [2:0] mem_grant
);

  // Address width used inside the state
  localparam int ADDR_W_L = bgic_pkg::ADDR_W;

  // Whole module state
  typedef struct packed {
    bgic_pkg::bgic_pins_type pin_s1;
    bgic_pkg::bgic_pins_type pin_s2;
    logic rd_q;
    logic wr_q;
    logic [1:0] rst_cnt;
    logic relocated;
    logic [15:0] reloc;
    logic [15:0] opcode;
    logic [15:0] link_lo;
    logic [15:0] link_hi;
    bgic_pkg::bgic_cfg_type cfg;
    bgic_pkg::bgic_bus_type bus;
    logic [3:0] wait_cnt;
    logic is_read;
    logic acc_hit;
    logic [ADDR_W_L-1:0] acc_addr;
    logic [15:0] acc_data;
    logic [15:0] data_out;
    logic data_oe;
    logic ready;
    logic [9:0] refr_cnt;
    logic refresh_req;
    logic [9:0] refresh_row;
    logic [3:0] row_strobe_en;
    logic [2:0] mem_grant;
  } bgic_state_type;

  bgic_state_type r_reg;
  bgic_state_type r_next;

  // Reset contents of the state
  function automatic bgic_state_type reset_state();
    bgic_state_type s;
    s = '0;
    s.reloc = bgic_pkg::RST_RELOC;
    s.cfg.wait_timing_select = 1'b1;
    s.cfg.refresh_scalar = bgic_pkg::RST_REFR;
    s.cfg.row_count = bgic_pkg::RST_GEOM[bgic_pkg::ROW_LSB +: 2];
    s.cfg.memory_config_code = bgic_pkg::RST_GEOM[bgic_pkg::CFG_LSB +: 2];
    s.cfg.chip_height_code = bgic_pkg::RST_GEOM[bgic_pkg::HT_LSB +: 3];
    s.cfg.prio_disp = bgic_pkg::RST_PDISP;
    s.cfg.prio_draw = bgic_pkg::RST_PDRAW;
    s.cfg.prio_host = bgic_pkg::RST_PHOST;
    s.cfg.memory_bus_wide = 1'b1;
    s.bus = bgic_pkg::BUS_IDLE;
    s.pin_s1.cs_n = 1'b1;
    s.pin_s1.rd_n = 1'b1;
    s.pin_s1.wr_n = 1'b1;
    s.pin_s2 = s.pin_s1;
    s.rd_q = 1'b1;
    s.wr_q = 1'b1;
    return s;
  endfunction

  // Current register word at a word offset
  function automatic logic [15:0] reg_word(bgic_state_type s, logic [6:0] ofs);
    logic [15:0] v;
    v = 16'h0000;
    case (ofs)
      bgic_pkg::OFS_RELOC: v = s.reloc;
      bgic_pkg::OFS_IFCTL:
      begin
        v[bgic_pkg::VR_BIT] = s.cfg.video_memory_select;
        v[bgic_pkg::WT_BIT] = s.cfg.wait_timing_select;
        v[bgic_pkg::HW_BIT] = s.cfg.host_width_select;
        v[bgic_pkg::GI_BIT] = s.cfg.drawing_engine_irq_flag;
        v[bgic_pkg::DI_BIT] = s.cfg.display_engine_irq_flag;
        v[bgic_pkg::WL1_BIT] = s.cfg.soft_write_lock;
        v[bgic_pkg::WL2_BIT] = s.cfg.hard_write_lock;
      end
      bgic_pkg::OFS_REFR: v[5:0] = s.cfg.refresh_scalar;
      bgic_pkg::OFS_GEOM:
        v[6:0] = {s.cfg.row_count, s.cfg.memory_config_code, s.cfg.chip_height_code};
      bgic_pkg::OFS_PDISP: v[5:0] = s.cfg.prio_disp;
      bgic_pkg::OFS_PDRAW: v[5:0] = s.cfg.prio_draw;
      bgic_pkg::OFS_PHOST: v[5:0] = s.cfg.prio_host;
      bgic_pkg::OFS_OPCODE: v = s.opcode;
      bgic_pkg::OFS_LINKLO: v = s.link_lo;
      bgic_pkg::OFS_LINKHI: v = s.link_hi;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // Merge host data into a word: byte lane in byte mode, whole word in word mode
  function automatic logic [15:0] merge(logic [15:0] old, logic [15:0] d,
                                        logic odd, logic wide);
    logic [15:0] v;
    v = old;
    if (wide)
      v = d;
    else if (odd)
      v[15:8] = d[7:0];
    else
      v[7:0] = d[7:0];
    return v;
  endfunction

  // Priority of one requester for a first or a follow-on transfer
  function automatic logic [2:0] level(bgic_pkg::bgic_prio_type p, logic burst);
    return burst ? p.subsequent_request_level : p.first_request_level;
  endfunction

  // Next-state logic
  always_comb
  begin
    logic rd_act;
    logic wr_act;
    logic [ADDR_W_L-1:0] ofs_full;
    logic [6:0] ofs;
    logic [15:0] wv;
    logic [15:0] rv;
    logic [2:0] best;
    logic [2:0] lv;
    rd_act = 1'b0;
    wr_act = 1'b0;
    ofs_full = '0;
    ofs = 7'h00;
    wv = 16'h0000;
    rv = 16'h0000;
    best = 3'h0;
    lv = 3'h0;
    r_next = r_reg;
    // Two-flop synchronisers on all host pins
    r_next.pin_s1 = pins;
    r_next.pin_s2 = r_reg.pin_s1;
    r_next.rd_q = r_reg.pin_s2.rd_n;
    r_next.wr_q = r_reg.pin_s2.wr_n;
    // Settle counter after reset release
    if (r_reg.rst_cnt != 2'h3)
      r_next.rst_cnt = r_reg.rst_cnt + 2'h1;
    // Catch the strap once the synchroniser holds post-reset samples
    if (r_reg.rst_cnt == bgic_pkg::RST_SETTLE)
      r_next.cfg.sync_mode = r_reg.pin_s2.byte_high_enable_pin; // R18
    // Async mode wants two agreeing samples of a strobe
    if (r_reg.cfg.sync_mode) // R19
    begin
      rd_act = !r_reg.pin_s2.rd_n;
      wr_act = !r_reg.pin_s2.wr_n;
    end
    else
    begin
      rd_act = !r_reg.pin_s2.rd_n && !r_reg.rd_q;
      wr_act = !r_reg.pin_s2.wr_n && !r_reg.wr_q;
    end
    // Host bus handshake
    ofs_full = r_reg.acc_addr - {r_reg.reloc[15:1], 1'b0};
    ofs = {ofs_full[6:1], 1'b0};
    case (r_reg.bus)
      bgic_pkg::BUS_IDLE:
      begin
        // Accept a strobe only after the strap has been caught
        if (r_reg.rst_cnt == 2'h3 && !r_reg.pin_s2.cs_n && (rd_act || wr_act))
        begin
          r_next.is_read = rd_act;
          r_next.acc_addr = r_reg.pin_s2.addr;
          r_next.acc_data = r_reg.pin_s2.data;
          if (!r_reg.relocated)
            r_next.acc_hit = !r_reg.pin_s2.mem_space; // R3 R5
          else
            r_next.acc_hit = (r_reg.pin_s2.mem_space == r_reg.cfg.memory_space_select) // R2
              && ((r_reg.pin_s2.addr - {r_reg.reloc[15:1], 1'b0})
                  < ADDR_W_L'(bgic_pkg::BLOCK_BYTES)); // R1
          if (r_reg.cfg.wait_timing_select && r_reg.cfg.sync_mode) // R7
            r_next.wait_cnt = rd_act ? bgic_pkg::WAIT_RD_LONG : bgic_pkg::WAIT_WR_LONG;
          else
            r_next.wait_cnt = rd_act ? bgic_pkg::WAIT_RD_SHORT : bgic_pkg::WAIT_WR_SHORT;
          r_next.bus = bgic_pkg::BUS_WAIT;
        end
      end
      bgic_pkg::BUS_WAIT:
      begin
        if (!r_reg.acc_hit)
          // Not ours: stay off the bus until the strobe goes away
          r_next.bus = bgic_pkg::BUS_HOLD;
        else if (r_reg.wait_cnt != 4'h0)
          r_next.wait_cnt = r_reg.wait_cnt - 4'h1;
        else
        begin
          r_next.ready = 1'b1; // R24
          r_next.bus = bgic_pkg::BUS_HOLD;
          if (!r_reg.relocated)
          begin
            // Before relocation only the relocation register answers
            if (r_reg.is_read)
            begin
              rv = (r_reg.acc_addr[6:0] == 7'h00) ? r_reg.reloc : 16'h0000; // R3
              r_next.data_out = merge(16'h0000, rv, 1'b0, 1'b1);
              r_next.data_oe = 1'b1;
            end
            else
            begin
              r_next.reloc = merge(r_reg.reloc, r_reg.acc_data, 1'b0,
                                   r_reg.cfg.host_width_select); // R5
              r_next.cfg.memory_space_select = r_reg.acc_data[bgic_pkg::MIO_BIT]; // R2
              r_next.relocated = 1'b1; // R4
            end
          end
          else if (r_reg.is_read)
          begin
            rv = reg_word(r_reg, ofs);
            // Byte mode returns the addressed byte on the low lane
            if (r_reg.cfg.host_width_select) // R8
              r_next.data_out = rv;
            else
              r_next.data_out = {8'h00, ofs_full[0] ? rv[15:8] : rv[7:0]};
            r_next.data_oe = 1'b1;
            // Reading the control word clears both interrupt flags
            if (ofs == bgic_pkg::OFS_IFCTL)
            begin
              r_next.cfg.drawing_engine_irq_flag = 1'b0; // R9
              r_next.cfg.display_engine_irq_flag = 1'b0; // R10
            end
          end
          else
          begin
            wv = merge(reg_word(r_reg, ofs), r_reg.acc_data, ofs_full[0],
                       r_reg.cfg.host_width_select); // R8
            if (ofs < bgic_pkg::BIU_END && r_reg.cfg.hard_write_lock)
            begin
              // Hard lock: nothing in the interface set changes
            end // R12
            else if (ofs < bgic_pkg::BIU_END && r_reg.cfg.soft_write_lock)
            begin
              if (ofs == bgic_pkg::OFS_IFCTL) // R11
              begin
                r_next.cfg.soft_write_lock = wv[bgic_pkg::WL1_BIT];
                r_next.cfg.hard_write_lock = wv[bgic_pkg::WL2_BIT];
              end
            end
            else
            begin
              case (ofs)
                bgic_pkg::OFS_RELOC:
                begin
                  r_next.reloc = wv;
                  r_next.cfg.memory_space_select = wv[bgic_pkg::MIO_BIT]; // R2
                end
                bgic_pkg::OFS_IFCTL:
                begin
                  // Irq flags are read-only here
                  r_next.cfg.video_memory_select = wv[bgic_pkg::VR_BIT]; // R6
                  r_next.cfg.wait_timing_select = wv[bgic_pkg::WT_BIT]; // R7
                  r_next.cfg.host_width_select = wv[bgic_pkg::HW_BIT]; // R8
                  r_next.cfg.soft_write_lock = wv[bgic_pkg::WL1_BIT]; // R11
                  r_next.cfg.hard_write_lock = wv[bgic_pkg::WL2_BIT]; // R12
                end
                bgic_pkg::OFS_REFR: r_next.cfg.refresh_scalar = wv[5:0]; // R13
                bgic_pkg::OFS_GEOM:
                begin
                  r_next.cfg.row_count = wv[bgic_pkg::ROW_LSB +: 2]; // R14
                  r_next.cfg.memory_config_code = wv[bgic_pkg::CFG_LSB +: 2]; // R15
                  r_next.cfg.chip_height_code = wv[bgic_pkg::HT_LSB +: 3]; // R16
                end
                bgic_pkg::OFS_PDISP: r_next.cfg.prio_disp = wv[5:0]; // R17
                bgic_pkg::OFS_PDRAW: r_next.cfg.prio_draw = wv[5:0]; // R17
                bgic_pkg::OFS_PHOST: r_next.cfg.prio_host = wv[5:0]; // R17
                bgic_pkg::OFS_OPCODE: r_next.opcode = wv;
                bgic_pkg::OFS_LINKLO: r_next.link_lo = wv;
                bgic_pkg::OFS_LINKHI: r_next.link_hi = wv;
                default:
                begin
                  // Reserved word: handshake completes, nothing stored
                end // R22
              endcase
            end
          end
        end
      end
      bgic_pkg::BUS_HOLD:
      begin
        // Keep ready and data up until both strobes are released
        if (r_reg.pin_s2.rd_n && r_reg.pin_s2.wr_n)
        begin
          r_next.ready = 1'b0;
          r_next.data_oe = 1'b0;
          r_next.bus = bgic_pkg::BUS_IDLE;
        end
      end
      default: r_next.bus = bgic_pkg::BUS_IDLE;
    endcase
    // Engine events; setting beats a same-cycle read clear
    if (draw_irq_event)
      r_next.cfg.drawing_engine_irq_flag = 1'b1; // R9
    if (disp_irq_event)
      r_next.cfg.display_engine_irq_flag = 1'b1; // R10
    // Refresh interval timer and row address
    r_next.refresh_req = 1'b0;
    if (r_reg.refr_cnt == 10'h000)
    begin
      r_next.refresh_req = 1'b1; // R13
      r_next.refresh_row = r_reg.refresh_row + 10'h001; // R23
      r_next.refr_cnt = 10'((r_reg.cfg.refresh_scalar + 10'h001) * bgic_pkg::REFR_UNIT - 1);
    end
    else
      r_next.refr_cnt = r_reg.refr_cnt - 10'h001;
    // Row strobe enables follow the configured row count
    case (r_reg.cfg.row_count) // R14
      2'h0: r_next.row_strobe_en = 4'h1;
      2'h1: r_next.row_strobe_en = 4'h3;
      2'h2: r_next.row_strobe_en = 4'h7;
      default: r_next.row_strobe_en = 4'hf;
    endcase
    // Arbitration: highest level wins, display before drawing before host
    r_next.mem_grant = 3'h0;
    for (int i = 0; i < 3; i++)
    begin
      lv = (i == 0) ? level(r_reg.cfg.prio_disp, mem_req_burst[0])
         : (i == 1) ? level(r_reg.cfg.prio_draw, mem_req_burst[1])
         : level(r_reg.cfg.prio_host, mem_req_burst[2]);
      if (mem_req[i] && (r_next.mem_grant == 3'h0 || lv > best)) // R17
      begin
        best = lv;
        r_next.mem_grant = 3'(1 << i);
      end
    end
    // Memory data path width is fixed
    r_next.cfg.memory_bus_wide = (bgic_pkg::GMEM_DATA_W == 16); // R21
  end

  // State register; reset loads defaults and clears flags
  always_ff @(posedge clk)
  begin
    if (srst)
      r_reg <= reset_state(); // R20
    else
      r_reg <= r_next;
  end

  // Outputs straight from state
  assign data_out = r_reg.data_out;
  assign data_oe = r_reg.data_oe;
  assign ready = r_reg.ready;
  assign cfg = r_reg.cfg;
  assign refresh_req = r_reg.refresh_req;
  assign refresh_row = r_reg.refresh_row;
  assign row_strobe_en = r_reg.row_strobe_en;
  assign mem_grant = r_reg.mem_grant;

endmodule

// [tb/bgic_regs_sva.sv]
// Concurrent checks on the register bank top ports.
// Assumes one clock domain and a bench that holds the strap steady.
`timescale 1ns/1ps
module bgic_regs_sva
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Host pins and answer
  input wire bgic_pkg::bgic_pins_type pins,
  input wire logic ready,
  input wire logic data_oe,
  // Engine events and memory side
  input wire logic draw_irq_event,
  input wire logic disp_irq_event,
  input wire logic [2:0] mem_req,
  input wire bgic_pkg::bgic_cfg_type cfg,
  input wire logic refresh_req,
  input wire logic [3:0] row_strobe_en,
  input wire logic [2:0] mem_grant
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Defaults must be present on the edge after any reset edge
  chk_reset_defaults: assert property (disable iff (1'b0) srst |=> (!ready && !refresh_req
    && cfg.refresh_scalar == bgic_pkg::RST_REFR && cfg.wait_timing_select
    && !cfg.drawing_engine_irq_flag && !cfg.display_engine_irq_flag && !cfg.hard_write_lock))
    else $error("register defaults missing after reset");
  chk_bus_wide: assert property (cfg.memory_bus_wide)
    else $error("graphics memory bus not wide");
  chk_draw_flag: assert property (draw_irq_event |=> cfg.drawing_engine_irq_flag)
    else $error("drawing flag not set by event");
  chk_disp_flag: assert property (disp_irq_event |=> cfg.display_engine_irq_flag)
    else $error("display flag not set by event");
  // Row strobes follow the row count one cycle later
  chk_row_gate: assert property (!$past(srst) |->
    row_strobe_en == 4'((5'h2 << $past(cfg.row_count)) - 5'h1))
    else $error("row strobe enables do not match row count");
  // Refresh requests stay at least nine clocks apart
  chk_refresh_gap: assert property (refresh_req |=> !refresh_req [*8])
    else $error("refresh requests too close");
  chk_grant_req: assert property (mem_grant != 3'h0 |->
    $onehot(mem_grant) && (mem_grant & $past(mem_req)) == mem_grant)
    else $error("grant without request or not one-hot");
  // Synchroniser plus minimum wait keeps ready five edges behind the strobe
  chk_ready_wait: assert property ($rose(ready) |->
    $past(!pins.cs_n && (!pins.rd_n || !pins.wr_n), 5))
    else $error("ready came too early");
  chk_sync_strap: assert property ($fell(srst) |-> ##6 cfg.sync_mode == pins.byte_high_enable_pin)
    else $error("sync mode does not follow strap");
  chk_read_drive: assert property ($rose(ready) && !pins.rd_n |-> data_oe)
    else $error("read answered without driving data");

  // Main scenarios reached
  cov_read: cover property ($rose(ready) && !pins.rd_n);
  cov_refresh: cover property (refresh_req);
  cov_flag_clear: cover property ($fell(cfg.drawing_engine_irq_flag));
endmodule

bind bgic_regs bgic_regs_sva u_sva (.clk(clk), .srst(srst), .pins(pins), .ready(ready),
  .data_oe(data_oe),
  .draw_irq_event(draw_irq_event), .disp_irq_event(disp_irq_event), .mem_req(mem_req),
  .cfg(cfg), .refresh_req(refresh_req), .row_strobe_en(row_strobe_en), .mem_grant(mem_grant));

// [tb/bgic_host.sv]
// Host processor model that drives the register bank pins.
// Assumes one clock; all pin changes follow a rising edge.
`timescale 1ns/1ps
module bgic_host
(
  // Clock
  input wire logic clk,
  // Device side
  output bgic_pkg::bgic_pins_type pins,
  input wire logic [15:0] data_out,
  input wire logic ready
);
  // Idle bus; strap held high to pick synchronous operation
  initial pins = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, mem_space: 1'b0,
    byte_high_enable_pin: 1'b1, addr: 16'h0000, data: 16'h0000};

  // One access; lat counts edges until ready, -1 when never answered
  task automatic acc(input bit wr, input bit ms, input logic [15:0] a, input logic [15:0] d,
    output logic [15:0] q, output int lat);
    int n;
    @(posedge clk);
    pins.cs_n <= 1'b0;
    pins.rd_n <= wr;
    pins.wr_n <= !wr;
    pins.mem_space <= ms;
    pins.addr <= a;
    pins.data <= wr ? d : ~pins.data;
    lat = 0;
    // Request stays put until ready is sampled high
    do
    begin
      @(posedge clk);
      lat++;
    end
    while (ready !== 1'b1 && lat < 24);
    q = data_out;
    if (ready !== 1'b1)
      lat = -1;
    // Release; the released data lines flip so no stale value lingers
    pins.cs_n <= 1'b1;
    pins.rd_n <= 1'b1;
    pins.wr_n <= 1'b1;
    pins.data <= ~pins.data;
    n = 0;
    // Next access only once ready has dropped
    while (ready !== 1'b0 && n < 10)
    begin
      @(posedge clk);
      n++;
    end
  endtask
endmodule

// [tb/bgic_tb.sv]
// Self-checking bench for the graphics bus interface register bank.
// Assumes the host model drives the pins and the checker is bound.
`timescale 1ns/1ps
module testbench;
  // Clock, reset and engine stimulus
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] evt = 2'b00;
  logic [2:0] mem_req = 3'b000;
  logic [2:0] mem_req_burst = 3'b000;
  // Host pins and device outputs
  bgic_pkg::bgic_pins_type pins;
  logic [15:0] data_out;
  logic data_oe;
  logic ready;
  bgic_pkg::bgic_cfg_type cfg;
  logic refresh_req;
  logic [9:0] refresh_row;
  logic [3:0] row_strobe_en;
  logic [2:0] mem_grant;
  // Bookkeeping
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [15:0] q;
  int lat;
  localparam logic [15:0] BASE = 16'h0080;

  always #2 clk = ~clk;

  bgic_host host (.clk(clk), .pins(pins), .data_out(data_out), .ready(ready));
  bgic_regs dut (.clk(clk), .srst(srst), .pins(pins), .data_out(data_out), .data_oe(data_oe),
    .ready(ready), .draw_irq_event(evt[0]), .disp_irq_event(evt[1]), .mem_req(mem_req),
    .mem_req_burst(mem_req_burst), .cfg(cfg), .refresh_req(refresh_req),
    .refresh_row(refresh_row), .row_strobe_en(row_strobe_en), .mem_grant(mem_grant));

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask
  // Word write and checked read inside the relocated block
  task automatic wr(input logic [6:0] o, input logic [15:0] d);
    host.acc(1, 1, BASE + 16'(o), d, q, lat);
  endtask
  task automatic rd(input logic [6:0] o, input logic [15:0] exp);
    host.acc(0, 1, BASE + 16'(o), 16'h0000, q, lat);
    chk(q, exp);
  endtask
  // Ten-cycle reset, then the settle time before the first strobe
  task automatic do_reset();
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // Defaults, unrelocated decode, relocation and width switch
  task automatic t_reloc();
    chk({10'h0, cfg.refresh_scalar}, {10'h0, bgic_pkg::RST_REFR});
    chk({15'h0, cfg.memory_bus_wide}, 16'h0001);
    chk({15'h0, cfg.sync_mode}, 16'h0001);
    host.acc(0, 0, 16'h3500, 16'h0000, q, lat);
    chk({8'h0, q[7:0]}, 16'h0000);
    host.acc(1, 0, 16'hab80, 16'h0081, q, lat);
    host.acc(0, 1, BASE, 16'h0000, q, lat);
    chk({8'h0, q[7:0]}, 16'h0081);
    host.acc(0, 0, BASE, 16'h0000, q, lat);
    chk(16'(lat), 16'hffff);
    host.acc(0, 1, BASE + 16'h0080, 16'h0000, q, lat);
    chk(16'(lat), 16'hffff);
    wr(bgic_pkg::OFS_IFCTL, 16'h0070);
    chk({15'h0, cfg.host_width_select}, 16'h0001);
    chk({15'h0, cfg.video_memory_select}, 16'h0001);
    rd(bgic_pkg::OFS_RELOC, 16'h0081);
    $display("test reloc done");
  endtask

  // Wait timing bit adds one wait to reads and to writes
  task automatic t_wait();
    int r1, r0, w1, w0;
    wr(bgic_pkg::OFS_IFCTL, 16'h0010);
    w1 = lat;
    chk({15'h0, cfg.video_memory_select}, 16'h0000);
    rd(bgic_pkg::OFS_IFCTL, 16'h0010);
    r0 = lat;
    wr(bgic_pkg::OFS_IFCTL, 16'h0030);
    w0 = lat;
    rd(bgic_pkg::OFS_IFCTL, 16'h0030);
    r1 = lat;
    chk(16'(r1 - r0), 16'h0001);
    chk(16'(w1 - w0), 16'h0001);
    $display("test wait done");
  endtask

  // Each engine event sets its flag; a control read clears it
  task automatic t_irq();
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      evt <= 2'(1 << i);
      @(posedge clk);
      evt <= 2'b00;
      rd(bgic_pkg::OFS_IFCTL, 16'h0030 | (16'h0008 >> i));
      rd(bgic_pkg::OFS_IFCTL, 16'h0030);
    end
    $display("test irq done");
  endtask

  // Geometry codes, row strobes, reserved and drawing locations
  task automatic t_geom();
    logic [6:0] v;
    for (int r = 0; r < 4; r++)
    begin
      v = {2'(r), 2'(3 - r), 3'(2 * r + 1)};
      wr(bgic_pkg::OFS_GEOM, {9'h0, v});
      rd(bgic_pkg::OFS_GEOM, {9'h0, v});
      chk({12'h0, row_strobe_en}, 16'((2 << r) - 1));
    end
    wr(7'h02, 16'hffff);
    rd(7'h02, 16'h0000);
    wr(bgic_pkg::OFS_OPCODE, 16'h5a01);
    rd(bgic_pkg::OFS_OPCODE, 16'h5a01);
    rd(7'h40, 16'h0000);
    $display("test geom done");
  endtask

  // Arbitration on first and follow-on levels
  task automatic t_prio();
    mem_req <= 3'b110;
    repeat (3) @(posedge clk);
    chk({13'h0, mem_grant}, 16'h0004);
    mem_req <= 3'b011;
    repeat (3) @(posedge clk);
    chk({13'h0, mem_grant}, 16'h0001);
    wr(bgic_pkg::OFS_PDISP, 16'h0007);
    repeat (2) @(posedge clk);
    chk({13'h0, mem_grant}, 16'h0002);
    mem_req_burst <= 3'b001;
    repeat (3) @(posedge clk);
    chk({13'h0, mem_grant}, 16'h0001);
    mem_req <= 3'b000;
    mem_req_burst <= 3'b000;
    $display("test prio done");
  endtask

  // Refresh spacing and row advance for two scalars
  task automatic t_refr();
    int n;
    logic [9:0] row0;
    for (int s = 0; s < 19; s += 18)
    begin
      wr(bgic_pkg::OFS_REFR, 16'(s));
      for (int k = 0; k < 2; k++)
      begin
        row0 = refresh_row;
        n = 0;
        do
        begin
          @(posedge clk);
          n++;
        end
        while (refresh_req !== 1'b1 && n < 2000);
      end
      chk(16'(n), 16'((s + 1) * 16));
      chk({6'h0, 10'(refresh_row - row0)}, 16'h0001);
    end
    $display("test refresh done");
  endtask

  // Soft lock lifted by a lock-bit write, then hard lock and a reset to lift it
  task automatic t_lock();
    wr(bgic_pkg::OFS_IFCTL, 16'h0032);
    wr(bgic_pkg::OFS_REFR, 16'h0005);
    chk(16'(lat > 0), 16'h0001);
    rd(bgic_pkg::OFS_REFR, 16'h0012);
    wr(bgic_pkg::OFS_IFCTL, 16'h0000);
    rd(bgic_pkg::OFS_IFCTL, 16'h0030);
    wr(bgic_pkg::OFS_IFCTL, 16'h0031);
    wr(bgic_pkg::OFS_IFCTL, 16'h0000);
    rd(bgic_pkg::OFS_IFCTL, 16'h0031);
    do_reset();
    chk({15'h0, cfg.hard_write_lock}, 16'h0000);
    chk({10'h0, cfg.prio_draw}, {10'h0, bgic_pkg::RST_PDRAW});
    chk({15'h0, cfg.host_width_select}, 16'h0000);
    $display("test lock done");
  endtask

  // Counts, verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    do_reset();
    t_reloc();
    t_wait();
    t_irq();
    t_geom();
    t_prio();
    t_refr();
    t_lock();
    stop_test();
  end

  // Whole run needs about a thousand cycles; this ceiling cuts a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      stop_test();
    end
  end
endmodule
